// ===== rtl/ccsr_pkg.sv
// Constants and carrier types for the charger control and status registers
package ccsr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] CCSR_MISC_CTRL_OFS = 8'h07;
    localparam logic [7:0] CCSR_OP_STATUS_OFS = 8'h08;

    // Misc control field positions
    localparam int CCSR_DET_FORCE_BIT = 7;
    localparam int CCSR_HALF_RATE_BIT = 6;
    localparam int CCSR_BSW_DIS_BIT   = 5;
    localparam int CCSR_WARM_VSEL_BIT = 4;
    localparam int CCSR_BSW_DLY_BIT   = 3;
    localparam int CCSR_BSW_RST_BIT   = 2;
    localparam int CCSR_TRACK_LSB     = 0;

    // Power-on values; watchdog returns only the masked bits to default
    localparam logic [7:0] CCSR_MISC_CTRL_RST = 8'h4C;
    localparam logic [7:0] CCSR_WDOG_MASK     = 8'hD4;

    // Operating status field positions
    localparam int CCSR_SRC_LSB   = 5;
    localparam int CCSR_PHASE_LSB = 3;
    localparam int CCSR_PG_BIT    = 2;
    localparam int CCSR_THERM_BIT = 1;
    localparam int CCSR_MINSYS_BIT = 0;

    // Input source type codes
    localparam logic [2:0] CCSR_SRC_NONE = 3'h0;
    localparam logic [2:0] CCSR_SRC_HOST = 3'h1;
    localparam logic [2:0] CCSR_SRC_ADPT = 3'h2;
    localparam logic [2:0] CCSR_SRC_OTG  = 3'h7;

    // Charge phase codes
    localparam logic [1:0] CCSR_PH_OFF  = 2'h0;
    localparam logic [1:0] CCSR_PH_PRE  = 2'h1;
    localparam logic [1:0] CCSR_PH_FAST = 2'h2;
    localparam logic [1:0] CCSR_PH_TERM = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Battery switch off delay: time in ms and derived cycles at 100 MHz
    localparam int CCSR_CLK_MHZ         = 100;
    localparam int CCSR_BSW_DLY_TIME_MS = 10;
    localparam int CCSR_BSW_DLY_CYCLES  = CCSR_BSW_DLY_TIME_MS * 1000 * CCSR_CLK_MHZ;

    // Battery switch sequencer
    typedef enum logic [1:0] {
        CCSR_BSW_ON   = 2'b00,
        CCSR_BSW_WAIT = 2'b01,
        CCSR_BSW_OFF  = 2'b10
    } ccsr_bsw_e;

    // Raw conditions from the analog side, not yet in the clock domain
    typedef struct packed {
        logic vbus_present;     // Input source attached
        logic otg_boost;        // Boost output active
        logic psel_high;        // Source select pin level
        logic charge_enable;    // Charging enabled
        logic below_precharge;  // Battery below pre-charge threshold
        logic charge_done;      // Charge terminated
        logic power_good;       // Input power good
        logic thermal_reg;      // In thermal regulation
        logic below_min_sys;    // Battery below minimum system voltage
        logic in_vdpm;          // In input voltage regulation
        logic in_idpm;          // In input current regulation
        logic cool_band;        // Battery in cool band
        logic warm_band;        // Battery in warm band
        logic detect_done;      // Forced input detection finished
    } ccsr_cond_s;

    // Register access strobe group from the serial bus engine
    typedef struct packed {
        logic       wr;         // Write strobe, one cycle
        logic       rd;         // Read strobe, one cycle
        logic [7:0] addr;       // Register offset
        logic [7:0] wdata;      // Write data
    } ccsr_req_s;

endpackage : ccsr_pkg

// ===== rtl/ccsr_regs.sv
// Charger misc control and operating status registers with their effects
// Function
// - Set detect bit forces input detection only while an input source is present
// - Detect bit self-clears when detection completes
// - Half-rate bit slows safety timer only in DPM, cool band or thermal regulation
// - Delay bit selects immediate or delayed off
// - Warm band voltage limited unless bit set
// - Reset-allow bit gates battery switch reset
// - Tracking field picks higher voltage limit
// - Source type field encodes input kind
// - Current limit reported elsewhere, not here
// - Charge phase field encodes charging state
// - Power good bit mirrors input power
// - Thermal bit mirrors thermal regulation
// - Min-system bit mirrors low battery
// - Register reset restores defaults, timer
`timescale 1ns/1ps
`default_nettype none

module ccsr_regs #(
    parameter int BSW_DLY_CYCLES = ccsr_pkg::CCSR_BSW_DLY_CYCLES
) (
    input  wire logic                 clk_i,              // 100 MHz clock
    input  wire logic                 rstn_i,             // Sync reset, active low
    input  wire ccsr_pkg::ccsr_req_s  req_i,              // Register access strobes
    output logic [7:0]                rdata_o,            // Read data, one cycle after rd
    input  wire ccsr_pkg::ccsr_cond_s cond_i,             // Raw analog conditions
    input  wire logic                 watchdog_expired_i, // Watchdog expiry pulse
    input  wire logic                 reg_reset_i,        // Register reset command pulse
    input  wire logic                 bsw_reset_req_i,    // Battery switch reset request
    input  wire logic [3:0]           vlim_reg_i,         // Register input voltage limit
    input  wire logic [3:0]           vlim_track_i,       // Battery-tracked voltage limit
    output logic                      detect_req_o,       // Force input detection
    output logic                      timer_half_o,       // Safety timer at half rate
    output logic                      bsw_on_o,           // Battery switch may conduct
    output logic                      bsw_reset_o,        // Battery switch reset permitted
    output logic                      vchg_capped_o,      // Charge voltage capped
    output logic [3:0]                vlim_eff_o,         // Effective input voltage limit
    output logic                      timer_reset_o,      // Safety timer reset pulse
    output logic                      reg_reset_done_o    // Register reset completed
);
    import ccsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [3:0] max4(input logic [3:0] a, input logic [3:0] b);
        max4 = (a > b) ? a : b;
    endfunction : max4

    function automatic logic hit(input ccsr_req_s r, input logic [7:0] ofs);
        hit = (r.addr == ofs);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser for analog conditions
    ccsr_cond_s cond_m_ff;
    ccsr_cond_s cond_ff;
    logic       done_d_ff;
    logic       done_pulse;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cond_m_ff <= '0;
            cond_ff   <= '0;
            done_d_ff <= 1'b0;
        end else begin
            cond_m_ff <= cond_i;
            cond_ff   <= cond_m_ff;
            done_d_ff <= cond_ff.detect_done;
        end
    end

    assign done_pulse = cond_ff.detect_done & ~done_d_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Misc control register
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic       ctrl_wr;

    assign ctrl_wr = req_i.wr & hit(req_i, CCSR_MISC_CTRL_OFS);

    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (done_pulse) begin
            nxt_ctrl[CCSR_DET_FORCE_BIT] = 1'b0;
        end
        if (watchdog_expired_i) begin
            nxt_ctrl = (ctrl_ff & ~CCSR_WDOG_MASK) | (CCSR_MISC_CTRL_RST & CCSR_WDOG_MASK);
        end
        // A host write in the completion cycle wins, so a new request is not lost
        if (ctrl_wr) begin
            nxt_ctrl = req_i.wdata;
        end
        if (reg_reset_i) begin
            nxt_ctrl = CCSR_MISC_CTRL_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl_ff <= CCSR_MISC_CTRL_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reset handshake: done pulse shows the command bit may drop
    logic rst_done_ff;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rst_done_ff <= 1'b0;
        end else begin
            rst_done_ff <= reg_reset_i;
        end
    end

    assign timer_reset_o    = rst_done_ff;
    assign reg_reset_done_o = rst_done_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Status word, built live from synchronised conditions
    logic [2:0] src_type;
    logic [1:0] phase;
    logic [7:0] status;

    assign src_type = cond_ff.otg_boost     ? CCSR_SRC_OTG  :
                      !cond_ff.vbus_present ? CCSR_SRC_NONE :
                      cond_ff.psel_high     ? CCSR_SRC_HOST : CCSR_SRC_ADPT;

    always_comb begin
        if (!cond_ff.charge_enable) begin
            phase = CCSR_PH_OFF;
        end else if (cond_ff.charge_done) begin
            phase = CCSR_PH_TERM;
        end else if (cond_ff.below_precharge) begin
            phase = CCSR_PH_PRE;
        end else begin
            phase = CCSR_PH_FAST;
        end
    end

    assign status = {src_type, phase, cond_ff.power_good, cond_ff.thermal_reg,
                     cond_ff.below_min_sys};

    ////////////////////////////////////////////////////////////////////////////
    // Read port; status writes fall through as no-ops
    logic [7:0] rdata_ff;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_ff <= 8'h00;
        end else if (req_i.rd) begin
            if (hit(req_i, CCSR_MISC_CTRL_OFS)) begin
                rdata_ff <= ctrl_ff;
            end else if (hit(req_i, CCSR_OP_STATUS_OFS)) begin
                rdata_ff <= status;
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    assign rdata_o = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Control effects
    // forced detection
    assign detect_req_o = ctrl_ff[CCSR_DET_FORCE_BIT] & cond_ff.vbus_present;
    assign timer_half_o = ctrl_ff[CCSR_HALF_RATE_BIT] &
                          (cond_ff.in_vdpm | cond_ff.in_idpm | cond_ff.cool_band |
                           cond_ff.thermal_reg);
    assign vchg_capped_o = cond_ff.warm_band & ~ctrl_ff[CCSR_WARM_VSEL_BIT];
    assign bsw_reset_o = bsw_reset_req_i & ctrl_ff[CCSR_BSW_RST_BIT];
    assign vlim_eff_o = (ctrl_ff[CCSR_TRACK_LSB +: 2] == 2'b00) ? vlim_reg_i
                                                              : max4(vlim_reg_i, vlim_track_i);
    ////////////////////////////////////////////////////////////////////////////
    // Battery switch sequencer
    ccsr_bsw_e   bsw_ff;
    ccsr_bsw_e   nxt_bsw;
    logic [31:0] dly_cnt_ff;
    logic        bsw_dis;

    assign bsw_dis = ctrl_ff[CCSR_BSW_DIS_BIT];

    always_comb begin
        nxt_bsw = bsw_ff;
        unique case (bsw_ff)
            CCSR_BSW_ON: begin
                if (bsw_dis) begin
                    nxt_bsw = ctrl_ff[CCSR_BSW_DLY_BIT] ? CCSR_BSW_WAIT : CCSR_BSW_OFF;
                end
            end
            CCSR_BSW_WAIT: begin
                if (!bsw_dis) begin
                    nxt_bsw = CCSR_BSW_ON;
                end else if (dly_cnt_ff >= 32'(BSW_DLY_CYCLES - 1)) begin
                    nxt_bsw = CCSR_BSW_OFF;
                end
            end
            CCSR_BSW_OFF: begin
                if (!bsw_dis) begin
                    nxt_bsw = CCSR_BSW_ON;
                end
            end
            default: begin
                nxt_bsw = CCSR_BSW_ON;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            bsw_ff <= CCSR_BSW_ON;
        end else begin
            bsw_ff <= nxt_bsw;
        end
    end

    // Counter only runs in the wait state, so a cancelled delay restarts in full
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            dly_cnt_ff <= 32'h0000_0000;
        end else if (bsw_ff == CCSR_BSW_WAIT) begin
            dly_cnt_ff <= dly_cnt_ff + 32'h0000_0001;
        end else begin
            dly_cnt_ff <= 32'h0000_0000;
        end
    end

    assign bsw_on_o = (bsw_ff != CCSR_BSW_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_detect_req;
        @(posedge clk_i) disable iff (!rstn_i)
        ctrl_ff[CCSR_DET_FORCE_BIT] && cond_ff.vbus_present |-> detect_req_o;
    endproperty
    a_detect_req: assert property (p_detect_req)
        else $error("detect request not raised");

    property p_detect_clear;
        @(posedge clk_i) disable iff (!rstn_i)
        done_pulse && !ctrl_wr && !watchdog_expired_i && !reg_reset_i
            |=> !ctrl_ff[CCSR_DET_FORCE_BIT];
    endproperty
    a_detect_clear: assert property (p_detect_clear)
        else $error("detect bit did not clear");

    property p_half_rate;
        @(posedge clk_i) disable iff (!rstn_i)
        !ctrl_ff[CCSR_HALF_RATE_BIT] |-> !timer_half_o;
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("timer slowed while disabled");

    property p_bsw_now;
        @(posedge clk_i) disable iff (!rstn_i)
        bsw_ff == CCSR_BSW_ON && bsw_dis && !ctrl_ff[CCSR_BSW_DLY_BIT] |=> !bsw_on_o;
    endproperty
    a_bsw_now: assert property (p_bsw_now)
        else $error("switch not off at once");

    property p_bsw_hold;
        @(posedge clk_i) disable iff (!rstn_i)
        bsw_ff == CCSR_BSW_WAIT && bsw_dis && dly_cnt_ff < 32'(BSW_DLY_CYCLES - 1)
            |=> bsw_on_o && bsw_ff == CCSR_BSW_WAIT;
    endproperty
    a_bsw_hold: assert property (p_bsw_hold)
        else $error("switch off before delay");

    property p_bsw_off;
        @(posedge clk_i) disable iff (!rstn_i)
        bsw_ff == CCSR_BSW_WAIT && bsw_dis && dly_cnt_ff == 32'(BSW_DLY_CYCLES - 1)
            |=> !bsw_on_o;
    endproperty
    a_bsw_off: assert property (p_bsw_off)
        else $error("switch still on after delay");

    property p_warm;
        @(posedge clk_i) disable iff (!rstn_i)
        vchg_capped_o |-> cond_ff.warm_band && !ctrl_ff[CCSR_WARM_VSEL_BIT];
    endproperty
    a_warm: assert property (p_warm)
        else $error("voltage cap wrongly applied");

    property p_bsw_rst;
        @(posedge clk_i) disable iff (!rstn_i)
        bsw_reset_o |-> ctrl_ff[CCSR_BSW_RST_BIT];
    endproperty
    a_bsw_rst: assert property (p_bsw_rst)
        else $error("switch reset while blocked");

    property p_track;
        @(posedge clk_i) disable iff (!rstn_i)
        ctrl_ff[CCSR_TRACK_LSB +: 2] != 2'b00 |-> vlim_eff_o >= vlim_reg_i
            && vlim_eff_o >= vlim_track_i;
    endproperty
    a_track: assert property (p_track)
        else $error("tracked limit below inputs");

    property p_stat_read;
        @(posedge clk_i) disable iff (!rstn_i)
        req_i.rd && hit(req_i, CCSR_OP_STATUS_OFS) |=> rdata_o == $past(status);
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("status read not live");

    property p_reg_reset;
        @(posedge clk_i) disable iff (!rstn_i)
        reg_reset_i |=> ctrl_ff == CCSR_MISC_CTRL_RST && timer_reset_o && reg_reset_done_o;
    endproperty
    a_reg_reset: assert property (p_reg_reset)
        else $error("register reset incomplete");

endmodule : ccsr_regs
`default_nettype wire

// ===== verification/ccsr_host_model.sv
// Host side model issuing single-byte register accesses and reset commands
`timescale 1ns/1ps
`default_nettype none

module ccsr_host_model (
    input  wire logic                clk_i,       // Bus clock
    input  wire logic [7:0]          rdata_i,     // Read data from registers
    output var  ccsr_pkg::ccsr_req_s req_o,       // Access strobes
    output logic                     reg_reset_o  // Register reset command
);
    import ccsr_pkg::*;

    initial begin
        req_o       = '0;
        reg_reset_o = 1'b0;
    end

    // Released bus shows a changing pattern so stale data is never trusted
    task automatic release_bus();
        req_o.wr    = 1'b0;
        req_o.rd    = 1'b0;
        req_o.addr  = ~req_o.addr;
        req_o.wdata = ~req_o.wdata;
    endtask : release_bus

    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        #1;
        req_o.wr    = 1'b1;
        req_o.addr  = addr;
        req_o.wdata = data;
        @(posedge clk_i);
        #1;
        release_bus();
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_i);
        #1;
        req_o.rd   = 1'b1;
        req_o.addr = addr;
        @(posedge clk_i);
        #1;
        data = rdata_i;
        release_bus();
    endtask : rd_reg

    task automatic reset_cmd();
        @(posedge clk_i);
        #1;
        reg_reset_o = 1'b1;
        @(posedge clk_i);
        #1;
        reg_reset_o = 1'b0;
    endtask : reset_cmd
endmodule : ccsr_host_model
`default_nettype wire

// ===== verification/charger_control_status_regs_tb_top.sv
// Self-checking bench for the charger control and status registers
`timescale 1ns/1ps
`default_nettype none

module charger_control_status_regs_tb_top;
    import ccsr_pkg::*;
    localparam int DLY = 16;
    logic       clk_i = 1'b0;
    logic       rstn_i = 1'b0;
    ccsr_req_s  req;
    ccsr_cond_s cond = '0;
    logic [7:0] rdata;
    logic       wdog = 1'b0;
    logic       reg_rst;
    logic       bsw_req = 1'b0;
    logic [3:0] vlim_reg = 4'h0;
    logic [3:0] vlim_trk = 4'h0;
    logic       det;
    logic       half;
    logic       bsw_on;
    logic       bsw_rst;
    logic       vlimited;
    logic [3:0] vlim_eff;
    logic       tmr_rst;
    logic       rst_done;
    int         n_errors = 0;
    int         num_checks = 0;
    int         seed = 32'h101c;
    logic [7:0] rd;
    logic [7:0] ctrl;
    ccsr_cond_s c;

    always #5 clk_i = ~clk_i;

    ccsr_regs #(.BSW_DLY_CYCLES(DLY)) i_ccsr_regs (
        .clk_i(clk_i), .rstn_i(rstn_i), .req_i(req), .rdata_o(rdata), .cond_i(cond),
        .watchdog_expired_i(wdog), .reg_reset_i(reg_rst), .bsw_reset_req_i(bsw_req),
        .vlim_reg_i(vlim_reg), .vlim_track_i(vlim_trk), .detect_req_o(det),
        .timer_half_o(half), .bsw_on_o(bsw_on), .bsw_reset_o(bsw_rst),
        .vchg_capped_o(vlimited), .vlim_eff_o(vlim_eff), .timer_reset_o(tmr_rst),
        .reg_reset_done_o(rst_done)
    );

    ccsr_host_model i_ccsr_host_model (
        .clk_i(clk_i), .rdata_i(rdata), .req_o(req), .reg_reset_o(reg_rst)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [7:0] exp_status(input ccsr_cond_s s);
        logic [2:0] src;
        logic [1:0] ph;
        src = s.otg_boost ? 3'h7 : (s.vbus_present ? (s.psel_high ? 3'h1 : 3'h2) : 3'h0);
        ph  = !s.charge_enable ? 2'h0 : (s.charge_done ? 2'h3 : (s.below_precharge ? 2'h1 : 2'h2));
        return {src, ph, s.power_good, s.thermal_reg, s.below_min_sys};
    endfunction : exp_status

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cycles

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cycles(6);
        rstn_i = 1'b1;
        i_ccsr_host_model.rd_reg(CCSR_MISC_CTRL_OFS, rd);
        check(rd, 8'h4C);
        i_ccsr_host_model.rd_reg(8'h3A, rd);
        check(rd, 8'h00);
        for (int i = 0; i < 40; i++) begin
            ctrl = 8'($random(seed)) & 8'hDF;
            c = ccsr_cond_s'(14'($random(seed)));
            c.detect_done = 1'b0;
            cond = c;
            vlim_reg = 4'($random(seed));
            vlim_trk = 4'($random(seed));
            bsw_req = 1'($random(seed));
            i_ccsr_host_model.wr_reg(CCSR_MISC_CTRL_OFS, ctrl);
            i_ccsr_host_model.wr_reg(CCSR_OP_STATUS_OFS, ~ctrl);
            i_ccsr_host_model.rd_reg(CCSR_OP_STATUS_OFS, rd);
            check(rd, exp_status(c));
            i_ccsr_host_model.rd_reg(CCSR_MISC_CTRL_OFS, rd);
            check(rd, ctrl);
            check({7'h0, det}, {7'h0, ctrl[7] & c.vbus_present});
            check({7'h0, half}, {7'h0, ctrl[6] & (c.in_vdpm | c.in_idpm | c.cool_band | c.thermal_reg)});
            check({7'h0, vlimited}, {7'h0, c.warm_band & ~ctrl[4]});
            check({7'h0, bsw_rst}, {7'h0, bsw_req & ctrl[2]});
            check({4'h0, vlim_eff}, {4'h0, (ctrl[1:0] == 2'b00 || vlim_reg > vlim_trk) ? vlim_reg : vlim_trk});
        end
        // Detect bit clears itself once detection completes
        cond = '0;
        i_ccsr_host_model.wr_reg(CCSR_MISC_CTRL_OFS, 8'h80);
        cond.detect_done = 1'b1;
        cycles(4);
        i_ccsr_host_model.rd_reg(CCSR_MISC_CTRL_OFS, rd);
        check(rd, 8'h00);
        // Immediate off, back on, then delayed off
        i_ccsr_host_model.wr_reg(CCSR_MISC_CTRL_OFS, 8'h20);
        cycles(1);
        check({7'h0, bsw_on}, 8'h00);
        i_ccsr_host_model.wr_reg(CCSR_MISC_CTRL_OFS, 8'h08);
        cycles(1);
        check({7'h0, bsw_on}, 8'h01);
        i_ccsr_host_model.wr_reg(CCSR_MISC_CTRL_OFS, 8'h28);
        cycles(DLY - 4);
        check({7'h0, bsw_on}, 8'h01);
        cycles(8);
        check({7'h0, bsw_on}, 8'h00);
        // Watchdog restores only its own subset of bits
        i_ccsr_host_model.wr_reg(CCSR_MISC_CTRL_OFS, 8'hA3);
        wdog = 1'b1;
        cycles(1);
        wdog = 1'b0;
        i_ccsr_host_model.rd_reg(CCSR_MISC_CTRL_OFS, rd);
        check(rd, (8'hA3 & ~CCSR_WDOG_MASK) | (8'h4C & CCSR_WDOG_MASK));
        i_ccsr_host_model.reset_cmd();
        check({6'h0, tmr_rst, rst_done}, 8'h03);
        i_ccsr_host_model.rd_reg(CCSR_MISC_CTRL_OFS, rd);
        check(rd, 8'h4C);
        check({7'h0, tmr_rst}, 8'h00);
        // Mid-run reset turns the switch back on and restores control defaults
        i_ccsr_host_model.wr_reg(CCSR_MISC_CTRL_OFS, 8'h23);
        cycles(1);
        check({7'h0, bsw_on}, 8'h00);
        rstn_i = 1'b0;
        cycles(3);
        rstn_i = 1'b1;
        check({7'h0, bsw_on}, 8'h01);
        i_ccsr_host_model.rd_reg(CCSR_MISC_CTRL_OFS, rd);
        check(rd, 8'h4C);
        wrap_up();
    end

    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end
endmodule : charger_control_status_regs_tb_top
`default_nettype wire
